// ---- inc/fdmc_pkg.sv ----
`default_nettype none

package fdmc_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int T_TICK_US        = 1000;
  localparam int TICK_CYCLES      = T_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int T_WAKE_US        = 150;
  localparam int WAKE_CYCLES      =
    (T_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longer than the slowest legal period (50 Hz)
  localparam int T_ABSENT_MS      = 25;
  localparam int ABSENT_CYCLES    = T_ABSENT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int T_QUIET_S        = 2;
  localparam int QUIET_TICKS      = T_QUIET_S * 1000000 / T_TICK_US;
  localparam int T_BACKOFF_STEP_S = 5;
  localparam int T_BACKOFF_MAX_S  = 25;
  localparam int BACKOFF_STEP     = T_BACKOFF_STEP_S * 1000000 / T_TICK_US;
  localparam int BACKOFF_MAX      = T_BACKOFF_MAX_S * 1000000 / T_TICK_US;
  // 4 samples of 25 ms worst case keep well under 200 ms
  localparam int T_PLAUS_MAX_MS   = 200;
  localparam int PLAUS_N          = 4;

  // ********************************************************************
  // Widths and levels
  // ********************************************************************
  localparam int CNT_W        = 22;
  localparam int NUM_W        = CNT_W + 7;
  localparam int TMR_W        = 16;
  localparam int DUTY_W       = 7;
  localparam int SPEED_W      = 8;
  localparam int ANA_W        = 8;
  localparam int LUT_AW       = 8;
  localparam int SAME_W       = 4;
  localparam int DERATE_SHIFT = 1;

  localparam logic [DUTY_W-1:0] DUTY_FULL    = 7'h64;
  localparam logic [DUTY_W-1:0] DUTY_ZERO    = 7'h00;
  localparam logic [DUTY_W-1:0] RUN_DUTY_MIN = 7'h0A;
  localparam logic [DUTY_W-1:0] RUN_DUTY_MAX = 7'h5F;
  localparam logic [ANA_W-1:0]  ANA_RUN_MIN  = 8'h19;
  localparam logic [NUM_W-1:0]  DIV_SCALE    = 29'h0000_0064;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    FDMC_QUIET  = 2'b00,
    FDMC_ACTIVE = 2'b01,
    FDMC_RUN    = 2'b10,
    FDMC_FAIL   = 2'b11
  } fdmc_mode_t;

  typedef struct packed {
    logic locked;
    logic overload;
    logic overcur;
    logic overheat;
    logic overtemp;
    logic supply_bad;
    logic selftest_bad;
  } fdmc_fault_t;

  typedef struct packed {
    logic               we;
    logic               sel;
    logic [DUTY_W-1:0]  idx;
    logic [SPEED_W-1:0] data;
  } fdmc_lut_wr_t;

  // Plain ramp until software loads real curves
  function automatic logic [SPEED_W-1:0] fdmc_lut_default(input int i);
    fdmc_lut_default = SPEED_W'((i % 128) * 2);
  endfunction

endpackage

`default_nettype wire

// ---- verilog/fdmc_lut.sv ----
`default_nettype none

module fdmc_lut
  import fdmc_pkg::*;
#(
  parameter int AW = fdmc_pkg::LUT_AW,
  parameter int DW = fdmc_pkg::SPEED_W
)
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Write side
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read side
  input  wire logic [AW-1:0] raddr_i,
  output var  logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  genvar g;
  generate
    for (g = 0; g < 2**AW; g++)
    begin : g_ent
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          mem[g] <= fdmc_lut_default(g);
        else if (we_i && waddr_i == AW'(g))
          mem[g] <= wdata_i;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= mem[raddr_i];
  end

endmodule

`default_nettype wire

// ---- verilog/fdmc_ctrl.sv ----
`default_nettype none

module fdmc_ctrl
#(
  parameter int TICK_CYCLES   = fdmc_pkg::TICK_CYCLES,
  parameter int WAKE_CYCLES   = fdmc_pkg::WAKE_CYCLES,
  parameter int ABSENT_CYCLES = fdmc_pkg::ABSENT_CYCLES,
  parameter int PLAUS_N       = fdmc_pkg::PLAUS_N
)
(
  // Clock and reset
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          RESETN_I,
  // Control unit lines
  input  wire logic                          PWM_N_I,
  input  wire logic [fdmc_pkg::ANA_W-1:0]    ANA_I,
  // Drive monitors
  input  wire fdmc_pkg::fdmc_fault_t         FAULT_I,
  // Table loading
  input  wire fdmc_pkg::fdmc_lut_wr_t        LUT_WR_I,
  // Status
  output var  fdmc_pkg::fdmc_mode_t          MODE_O,
  output var  logic [fdmc_pkg::SPEED_W-1:0]  SPEED_O,
  output var  logic                          MOTOR_ON_O,
  output var  logic [fdmc_pkg::DUTY_W-1:0]   DUTY_O,
  output var  logic                          DUTY_OK_O
);

  import fdmc_pkg::*;

  // ********************************************************************
  // Period and high-time measurement
  // ********************************************************************
  logic                pin_d;
  logic [CNT_W-1:0]    per_cnt;
  logic [CNT_W-1:0]    hi_cnt;
  logic [CNT_W-1:0]    low_cnt;
  wire                 fall      = pin_d & ~PWM_N_I;
  wire                 absent_to = per_cnt == CNT_W'(ABSENT_CYCLES - 1);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pin_d   <= 1'b1;
      per_cnt <= '0;
      hi_cnt  <= '0;
      low_cnt <= '0;
    end
    else
    begin
      pin_d <= PWM_N_I;
      if (fall || absent_to)
      begin
        per_cnt <= CNT_W'(1);
        hi_cnt  <= CNT_W'(PWM_N_I);
      end
      else
      begin
        per_cnt <= per_cnt + CNT_W'(1);
        hi_cnt  <= hi_cnt + CNT_W'(PWM_N_I);
      end
      if (PWM_N_I)
        low_cnt <= '0;
      else if (low_cnt != '1)
        low_cnt <= low_cnt + CNT_W'(1);
    end
  end

  // ********************************************************************
  // Duty percent by restoring division
  // ********************************************************************
  logic                div_busy;
  logic [2:0]          div_bit;
  logic [NUM_W-1:0]    div_num;
  logic [CNT_W-1:0]    div_den;
  logic [DUTY_W-1:0]   div_quo;
  logic                meas_stb;
  logic [DUTY_W-1:0]   meas_val;
  wire  [NUM_W-1:0]    den_sh  = NUM_W'(div_den) << div_bit;
  wire                 div_ge  = div_num >= den_sh;
  wire  [DUTY_W-1:0]   quo_nx  = div_quo | (DUTY_W'(div_ge) << div_bit);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      div_busy <= 1'b0;
      div_bit  <= '0;
      div_num  <= '0;
      div_den  <= '0;
      div_quo  <= '0;
      meas_stb <= 1'b0;
      meas_val <= '0;
    end
    else
    begin
      meas_stb <= 1'b0;
      if (absent_to)
      begin
        // Flat line: level alone gives 0 % or 100 %
        div_busy <= 1'b0;
        meas_stb <= 1'b1;
        meas_val <= PWM_N_I ? DUTY_FULL : DUTY_ZERO;
      end
      else if (fall)
      begin
        div_busy <= 1'b1;
        div_bit  <= 3'h6;
        div_num  <= NUM_W'(hi_cnt) * DIV_SCALE;
        div_den  <= per_cnt;
        div_quo  <= '0;
      end
      else if (div_busy)
      begin
        div_quo <= quo_nx;
        if (div_ge)
          div_num <= div_num - den_sh;
        div_bit <= div_bit - 3'h1;
        if (div_bit == 3'h0)
        begin
          div_busy <= 1'b0;
          meas_stb <= 1'b1;
          meas_val <= quo_nx;
        end
      end
    end
  end

  // ********************************************************************
  // Plausibility filter
  // ********************************************************************
  logic [DUTY_W-1:0]   last_val;
  logic [SAME_W-1:0]   same_cnt;
  logic [DUTY_W-1:0]   duty;
  logic                duty_valid;
  wire                 same_nx   = meas_val == last_val;
  wire                 duty_take =
    meas_stb && same_nx && same_cnt >= SAME_W'(PLAUS_N - 1);

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      last_val   <= '0;
      same_cnt   <= '0;
      duty       <= '0;
      duty_valid <= 1'b0;
    end
    else if (meas_stb)
    begin
      last_val <= meas_val;
      if (!same_nx)
        same_cnt <= SAME_W'(1);
      else if (same_cnt != '1)
        same_cnt <= same_cnt + SAME_W'(1);
      if (duty_take)
      begin
        duty       <= meas_val;
        duty_valid <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Requests and faults
  // ********************************************************************
  wire absent    = duty_valid && duty == DUTY_FULL;
  wire ana_sel   = duty_valid && duty == DUTY_ZERO;
  wire dig_req   = duty_valid && duty >= RUN_DUTY_MIN
                   && duty <= RUN_DUTY_MAX;
  wire ana_req   = ana_sel && ANA_I >= ANA_RUN_MIN;
  wire run_req   = dig_req || ana_req;
  wire wake      = low_cnt > CNT_W'(WAKE_CYCLES);
  wire stop_oth  = FAULT_I.overcur || FAULT_I.overtemp
                   || FAULT_I.supply_bad
                   || FAULT_I.selftest_bad;
  wire fault_stop = stop_oth || FAULT_I.locked;
  wire derate    = FAULT_I.overload || FAULT_I.overheat;

  // ********************************************************************
  // Tick prescaler and second-scale timers
  // ********************************************************************
  fdmc_mode_t          state;
  fdmc_mode_t          next_state;
  logic [CNT_W-1:0]    tick_cnt;
  logic                tick;
  logic [TMR_W-1:0]    qtmr;
  logic [TMR_W-1:0]    btmr;
  logic [TMR_W-1:0]    backoff;
  logic                lock_fault;
  logic                lock_seen;
  wire                 quiet_due = qtmr >= TMR_W'(QUIET_TICKS);
  wire                 fail_in   = next_state == FDMC_FAIL
                                   && state != FDMC_FAIL;
  wire                 retry_ok  = lock_fault ? (btmr >= backoff)
                                              : !fault_stop;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= tick_cnt == CNT_W'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == CNT_W'(TICK_CYCLES - 1))
                  ? '0 : tick_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      qtmr <= '0;
      btmr <= '0;
    end
    else
    begin
      if (state == FDMC_QUIET || !absent)
        qtmr <= '0;
      else if (tick && !quiet_due)
        qtmr <= qtmr + TMR_W'(1);
      if (state != FDMC_FAIL || !lock_fault)
        btmr <= '0;
      else if (tick && btmr != '1)
        btmr <= btmr + TMR_W'(1);
    end
  end

  // Backoff grows per failed retry, drops once duty stops asking to run
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      backoff    <= TMR_W'(BACKOFF_STEP);
      lock_seen  <= 1'b0;
      lock_fault <= 1'b0;
    end
    else if (fail_in)
    begin
      lock_fault <= FAULT_I.locked && !stop_oth;
      if (FAULT_I.locked)
      begin
        lock_seen <= 1'b1;
        if (lock_seen)
          backoff <= (backoff >= TMR_W'(BACKOFF_MAX - BACKOFF_STEP))
                     ? TMR_W'(BACKOFF_MAX)
                     : backoff + TMR_W'(BACKOFF_STEP);
      end
    end
    else if (!dig_req)
    begin
      backoff   <= TMR_W'(BACKOFF_STEP);
      lock_seen <= 1'b0;
    end
  end

  // ********************************************************************
  // Mode sequencer
  // ********************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      FDMC_QUIET:
        if (wake)
          next_state = FDMC_ACTIVE;
      FDMC_ACTIVE:
        if (quiet_due)
          next_state = FDMC_QUIET;
        else if (fault_stop)
          next_state = FDMC_FAIL;
        else if (run_req)
          next_state = FDMC_RUN;
      FDMC_RUN:
        if (quiet_due)
          next_state = FDMC_QUIET;
        else if (fault_stop)
          next_state = FDMC_FAIL;
        else if (!run_req)
          next_state = FDMC_ACTIVE;
      FDMC_FAIL:
        if (quiet_due)
          next_state = FDMC_QUIET;
        else if (dig_req && retry_ok)
          next_state = FDMC_RUN;
      default:
        next_state = FDMC_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      state <= FDMC_ACTIVE;
    else
      state <= next_state;
  end

  // ********************************************************************
  // Speed set-point
  // ********************************************************************
  // Duty keeps priority; analogue only while the line is held dominant
  wire [LUT_AW-1:0]    lut_addr = ana_sel
                                  ? {1'b1, ANA_I[ANA_W-1:1]}
                                  : {1'b0, duty};
  wire [LUT_AW-1:0]    lut_waddr = {LUT_WR_I.sel, LUT_WR_I.idx};
  logic [SPEED_W-1:0]  lut_q;
  wire [SPEED_W-1:0]   next_speed =
    (state != FDMC_RUN || fault_stop) ? '0
    : derate ? (lut_q >> DERATE_SHIFT) : lut_q;

  fdmc_lut #(
    .AW (LUT_AW),
    .DW (SPEED_W)
  ) u_lut (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .we_i    (LUT_WR_I.we),
    .waddr_i (lut_waddr),
    .wdata_i (LUT_WR_I.data),
    .raddr_i (lut_addr),
    .rdata_o (lut_q)
  );

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      SPEED_O <= '0;
    else
      SPEED_O <= next_speed;
  end

  assign MODE_O     = state;
  assign MOTOR_ON_O = state == FDMC_RUN;
  assign DUTY_O     = duty;
  assign DUTY_OK_O  = duty_valid;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  sequence s_enter_quiet;
    state != FDMC_QUIET && next_state == FDMC_QUIET;
  endsequence

  sequence s_derate_run;
    state == FDMC_RUN && !fault_stop && derate;
  endsequence

  a_quiet_wait:
    assert property (s_enter_quiet |-> absent && quiet_due)
    else $error("Quiet entered without full 2 s wait");
  a_wake_pulse:
    assert property (state == FDMC_QUIET && next_state == FDMC_ACTIVE
                     |-> $past(!PWM_N_I) && low_cnt > CNT_W'(WAKE_CYCLES))
    else $error("Woke without long enough dominant pulse");
  a_fault_fail:
    assert property (state == FDMC_RUN && fault_stop && !quiet_due
                     |=> state == FDMC_FAIL)
    else $error("Stopping fault did not enter failure");
  a_overcur_stop:
    assert property (FAULT_I.overcur |=> SPEED_O == '0)
    else $error("Speed nonzero after over-current");
  a_derate_half:
    assert property (s_derate_run |=>
                     SPEED_O == ($past(lut_q) >> DERATE_SHIFT))
    else $error("Derated speed not reduced");
  a_duty_run:
    assert property (state == FDMC_ACTIVE && dig_req && !fault_stop
                     && !quiet_due |=> state == FDMC_RUN)
    else $error("Duty run request not followed");
  a_ana_run:
    assert property (state == FDMC_ACTIVE && ana_req && !fault_stop
                     && !quiet_due |=> MOTOR_ON_O)
    else $error("Analogue run request not followed");
  a_mixed_prio:
    assert property (dig_req |-> !lut_addr[LUT_AW-1])
    else $error("Analogue table used while duty requests run");
  a_plaus_hold:
    assert property (!$stable(duty) |-> $past(meas_stb)
                     && $past(same_nx))
    else $error("Duty changed without equal measurements");
  a_flat_high:
    assert property (absent_to && PWM_N_I
                     |=> meas_stb && meas_val == DUTY_FULL)
    else $error("Recessive line not read as 100 percent");
  a_backoff_cap:
    assert property (backoff >= TMR_W'(BACKOFF_STEP)
                     && backoff <= TMR_W'(BACKOFF_MAX))
    else $error("Retry backoff outside 5 s to 25 s");

endmodule

`default_nettype wire

// ---- tb/fdmc_ccu_model.sv ----
`default_nettype none

module fdmc_ccu_model
(
  // Clock
  input  wire logic       clk_i,
  // Line control
  input  wire logic       pwm_en_i,
  input  wire logic       level_i,
  input  wire logic [7:0] high_i,
  // Line to the drive
  output var  logic       pwm_n_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;

  int         pos   = 0;
  logic       en_q  = 1'b0;
  logic       lvl_q = 1'b1;
  logic [7:0] hi_q  = 8'h00;

  // Controls taken on the rising edge so the line never races the bench
  always @(posedge clk_i)
  begin
    en_q  <= pwm_en_i;
    lvl_q <= level_i;
    hi_q  <= high_i;
  end

  // Fixed 100-cycle period, well away from the test band
  always @(negedge clk_i)
  begin
    pos = (pos + 1) % 100;
    pwm_n_o <= en_q ? (pos < int'(hi_q)) : lvl_q;
  end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fdmc_pkg::*;

  // Short tick keeps the backoff runs inside the cycle budget
  localparam int TK = 2;

  logic         CLK_SYS_I = 1'b0;
  logic         RESETN_I  = 1'b0;
  logic         pwm_en    = 1'b0;
  logic         lvl       = 1'b1;
  logic [7:0]   hi        = 8'h00;
  logic [7:0]   ANA_I     = 8'h00;
  fdmc_fault_t  FAULT_I   = '0;
  fdmc_lut_wr_t LUT_WR_I  = '0;
  wire          pwm_n;
  fdmc_mode_t   MODE_O;
  logic [7:0]   SPEED_O;
  logic         MOTOR_ON_O;
  logic [6:0]   DUTY_O;
  logic         DUTY_OK_O;
  logic [7:0]   dtab [0:127];
  logic [7:0]   atab [0:127];
  int           bad_count   = 0;
  int           comparisons = 0;
  int           dl [7]      = '{5, 96, 10, 95, 0, 0, 0};
  int           d;

  always #5 CLK_SYS_I = ~CLK_SYS_I;

  fdmc_ccu_model CCU (.clk_i(CLK_SYS_I), .pwm_en_i(pwm_en), .level_i(lvl),
                      .high_i(hi), .pwm_n_o(pwm_n));

  fdmc_ctrl #(.TICK_CYCLES(TK), .WAKE_CYCLES(20), .ABSENT_CYCLES(200),
              .PLAUS_N(4)) DUT (
    .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PWM_N_I(pwm_n),
    .ANA_I(ANA_I), .FAULT_I(FAULT_I), .LUT_WR_I(LUT_WR_I),
    .MODE_O(MODE_O), .SPEED_O(SPEED_O), .MOTOR_ON_O(MOTOR_ON_O),
    .DUTY_O(DUTY_O), .DUTY_OK_O(DUTY_OK_O));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS_I);
  endtask

  task automatic wmode(input fdmc_mode_t m, input int lim);
    for (int i = 0; i < lim && MODE_O !== m; i++)
      cyc(1);
    chk("mode wait", 32'(m), 32'(MODE_O));
    if (MODE_O !== m)
      results();
  endtask

  function automatic logic [7:0] exp_spd(input int i, input logic der);
    exp_spd = der ? (dtab[i] >> 1) : dtab[i];
  endfunction

  function automatic fdmc_mode_t exp_mode(input int dv);
    exp_mode = (dv >= 10 && dv <= 95) ? FDMC_RUN : FDMC_ACTIVE;
  endfunction

  task automatic set_duty(input int dv);
    pwm_en = 1'b1;
    hi = 8'(dv);
    for (int i = 0; i < 3000 && DUTY_O !== 7'(dv); i++)
      cyc(1);
    chk("duty", 32'(dv), 32'(DUTY_O));
    chk("duty ok", 1, 32'(DUTY_OK_O));
    cyc(3);
  endtask

  task automatic lut_wr(input logic s, input logic [6:0] i,
                        input logic [7:0] v);
    LUT_WR_I = '{we: 1'b1, sel: s, idx: i, data: v};
    cyc(1);
    LUT_WR_I.we = 1'b0;
    if (s)
      atab[i] = v;
    else
      dtab[i] = v;
    cyc(1);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    void'($urandom(32'hcc80));
    for (int i = 0; i < 128; i++)
    begin
      dtab[i] = 8'((i * 2) % 256);
      atab[i] = 8'((i * 2) % 256);
    end
    cyc(3);
    RESETN_I = 1'b1;
    chk("mode", 32'(FDMC_ACTIVE), 32'(MODE_O));
    chk("speed", 0, 32'(SPEED_O));
    chk("motor", 0, 32'(MOTOR_ON_O));
    chk("duty ok", 0, 32'(DUTY_OK_O));
    $display("test reset done");
    cyc(1);
    for (int k = 4; k < 7; k++)
      dl[k] = 10 + int'($urandom % 86);
    foreach (dl[k])
    begin
      set_duty(dl[k]);
      chk("mode", 32'(exp_mode(dl[k])), 32'(MODE_O));
      chk("motor", 32'(exp_mode(dl[k]) == FDMC_RUN),
          32'(MOTOR_ON_O));
      chk("speed", exp_mode(dl[k]) == FDMC_RUN ? 32'(dtab[dl[k]]) : 0,
          32'(SPEED_O));
    end
    $display("test duty band done");
    d = 20 + int'($urandom % 60);
    lut_wr(1'b0, 7'(d), 8'($urandom));
    lut_wr(1'b1, 7'h40, 8'($urandom));
    set_duty(d);
    chk("speed", 32'(exp_spd(d, 1'b0)), 32'(SPEED_O));
    FAULT_I.overload = 1'b1;
    cyc(3);
    chk("speed", 32'(exp_spd(d, 1'b1)), 32'(SPEED_O));
    FAULT_I = '0;
    FAULT_I.overheat = 1'b1;
    cyc(3);
    chk("speed", 32'(exp_spd(d, 1'b1)), 32'(SPEED_O));
    FAULT_I = '0;
    $display("test table and derate done");
    foreach (dl[k])
    begin
      if (k > 3)
        continue;
      FAULT_I = 7'(1 << (k == 3 ? 4 : k));
      cyc(3);
      chk("mode", 32'(FDMC_FAIL), 32'(MODE_O));
      chk("speed", 0, 32'(SPEED_O));
      chk("motor", 0, 32'(MOTOR_ON_O));
      FAULT_I = '0;
      wmode(FDMC_RUN, 50);
    end
    $display("test stopping faults done");
    for (int n = 1; n < 3; n++)
    begin
      FAULT_I.locked = 1'b1;
      cyc(3);
      FAULT_I = '0;
      chk("mode", 32'(FDMC_FAIL), 32'(MODE_O));
      cyc(n * 4500 * TK);
      chk("mode", 32'(FDMC_FAIL), 32'(MODE_O));
      wmode(FDMC_RUN, n * 1000 * TK);
    end
    $display("test locked backoff done");
    pwm_en = 1'b0;
    lvl = 1'b0;
    ANA_I = 8'h80;
    for (int i = 0; i < 5000 && DUTY_O !== 7'h00; i++)
      cyc(1);
    chk("duty", 0, 32'(DUTY_O));
    wmode(FDMC_RUN, 100);
    cyc(3);
    chk("speed", 32'(atab[64]), 32'(SPEED_O));
    ANA_I = 8'h10;
    wmode(FDMC_ACTIVE, 100);
    ANA_I = 8'h80;
    set_duty(30);
    chk("speed", 32'(exp_spd(30, 1'b0)), 32'(SPEED_O));
    $display("test analogue done");
    pwm_en = 1'b0;
    lvl = 1'b1;
    for (int i = 0; i < 3000 && DUTY_O !== 7'h64; i++)
      cyc(1);
    chk("duty", 32'h64, 32'(DUTY_O));
    cyc(2500);
    chk("mode", 32'(FDMC_ACTIVE), 32'(MODE_O));
    wmode(FDMC_QUIET, 2500);
    lvl = 1'b0;
    cyc(15);
    lvl = 1'b1;
    cyc(30);
    chk("mode", 32'(FDMC_QUIET), 32'(MODE_O));
    lvl = 1'b0;
    cyc(30);
    lvl = 1'b1;
    wmode(FDMC_ACTIVE, 20);
    set_duty(60);
    chk("mode", 32'(FDMC_RUN), 32'(MODE_O));
    $display("test quiet and wake done");
    results();
  end
endmodule

`default_nettype wire
